/* File: hw/gpbr_pkg.sv */
package gpbr_pkg;

  // ==========================================================
  // Bus and port widths
  // ==========================================================
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int IDX_W = 14;

  // ==========================================================
  // Register indices; byte address is four times the index
  // ==========================================================
  localparam logic [IDX_W-1:0] IDX_B_OUT_LATCH = 14'h0002;
  localparam logic [IDX_W-1:0] IDX_D_OUT_LATCH = 14'h0004;
  localparam logic [IDX_W-1:0] IDX_B_PIN_READ = 14'h000f;
  localparam logic [IDX_W-1:0] IDX_B_DIR = 14'h0f1c;
  localparam logic [IDX_W-1:0] IDX_D_DIR = 14'h0f1e;
  localparam logic [IDX_W-1:0] IDX_B_PULLUP = 14'h0f29;
  localparam logic [IDX_W-1:0] IDX_D_PULLUP = 14'h0f2b;
  localparam logic [IDX_W-1:0] IDX_D_ANALOG_SEL = 14'h0f38;
  localparam logic [IDX_W-1:0] IDX_B_DRIVE_SEL = 14'h0f43;
  localparam logic [IDX_W-1:0] IDX_D_WAKE_EN = 14'h0f50;

  // ==========================================================
  // Reset values and writable bit masks
  // ==========================================================
  localparam logic [PORT_W-1:0] RST_ZERO = 8'h00;
  localparam logic [PORT_W-1:0] MASK_ALL = 8'hff;
  localparam logic [PORT_W-1:0] MASK_B_NO43 = 8'he7;
  localparam logic [PORT_W-1:0] B_ALWAYS_READ = 8'h18;

  // ==========================================================
  // Bus encodings
  // ==========================================================
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

endpackage

/* File: hw/gpbr_reg_byte.sv */
`timescale 1ns/1ps
module gpbr_reg_byte #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Write port
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  // Stored value
  output logic [7:0] q_r
);

  // Bits outside the mask hold their reset value and read it back
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RST_VAL;
    end else if (wrEn) begin
      q_r <= (wrData & WMASK) | (RST_VAL & ~WMASK);
    end
  end

endmodule

/* File: hw/gpbr_pin_cell.sv */
`timescale 1ns/1ps
module gpbr_pin_cell #(
  parameter bit OD_CAPABLE = 1'b1,
  parameter bit ALWAYS_READ = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Settings for this bit
  input wire logic dirOut,
  input wire logic openDrain,
  input wire logic latchBit,
  input wire logic pullupEn,
  // Pin
  input wire logic pinIn,
  output logic pinOut_r,
  output logic pinOe_r,
  output logic pullupOn_r,
  // Readback value
  output logic readBit
);

  logic odMode;

  assign odMode = openDrain & OD_CAPABLE;

  // Open drain only ever sinks; a high latch bit releases the pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut_r <= 1'b0;
      pinOe_r <= 1'b0;
    end else begin
      pinOut_r <= odMode ? 1'b0 : latchBit;
      pinOe_r <= dirOut & ~(odMode & latchBit);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pullupOn_r <= 1'b0;
    end else begin
      pullupOn_r <= pullupEn & (~dirOut | odMode);
    end
  end

  assign readBit = (ALWAYS_READ | ~dirOut | odMode) ? pinIn : 1'b0;

endmodule

/* File: hw/gpbr_gpio_top.sv */
`timescale 1ns/1ps
// What this block does
// - Port b pull-up control is 8 bits, resets to zero, bits 7,6,5,2,1,0 writable and bits 4,3 read zero.
// - A port b pin whose pull-up enable bit is zero never has its pull-up connected.
// - A port b pull-up connects only when enabled and the pin is an input or an open-drain output.
// - Port b bits 0-2 and 5-7 read the pin when input or open-drain output, otherwise zero.
// - Those bits decode as: direction 0 gives pin, output push-pull gives 0, output open-drain gives pin.
// - Port b bits 4 and 3 always read the live pin level.
// - Port d has eight pins, each set to input or output on its own.
// - Each port d pin can also serve an analog input channel and a key-on wakeup input.
// - The port d pull-up can connect only while that pin is an input.
// - Port d output latch is 8 bits read/write, resets to zero, and drives 0 low and 1 high in output mode.
// - Direction bits reset to zero; 0 is input and 1 is output.
// - Port b drive select 0 is push-pull and 1 is sink-only open drain.
module gpbr_gpio_top #(
  parameter int PW = gpbr_pkg::PORT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [gpbr_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [gpbr_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [gpbr_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port b pins
  input wire logic [PW-1:0] portBIn,
  output logic [PW-1:0] portBOut,
  output logic [PW-1:0] portBOe,
  output logic [PW-1:0] portBPullupOn,
  // Port d pins
  input wire logic [PW-1:0] portDIn,
  output logic [PW-1:0] portDOut,
  output logic [PW-1:0] portDOe,
  output logic [PW-1:0] portDPullupOn,
  // Secondary functions of port d
  output logic [PW-1:0] analogInSel,
  output logic [PW-1:0] keyonWakeEn
);
  import gpbr_pkg::*;

  // ==========================================================
  // Bus address phase capture
  // ==========================================================
  logic addrValid;
  logic wrPend_r;
  logic [IDX_W-1:0] wrIdx_r;
  logic [IDX_W-1:0] addrIdx;
  logic [DATA_W-1:0] rdData_nxt;
  logic [DATA_W-1:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // Size is not decoded: a narrow write still lands on the whole low byte
  assign addrValid = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign addrIdx = haddr[ADDR_W-1:2];

  // The slave never stalls, so a write is committed in the data phase that follows
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
    end else begin
      wrPend_r <= addrValid & hwrite;
    end
  end

  // Only a taken address phase moves the index, so idle cycles keep the last one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrIdx_r <= '0;
    end else if (addrValid) begin
      wrIdx_r <= addrIdx;
    end
  end

  // ==========================================================
  // Bus response
  // ==========================================================
  // Zero wait states: every transfer completes in its first data phase
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= 1'b1;
    end
  end

  // Every access is legal, so the response never signals an error
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hresp_r <= HRESP_OKAY;
    end else begin
      hresp_r <= HRESP_OKAY;
    end
  end

  // ==========================================================
  // Register write strobes
  // ==========================================================
  logic [PW-1:0] wrByte;
  logic weBLatch;
  logic weDLatch;
  logic weBDir;
  logic weDDir;
  logic weBPullup;
  logic weDPullup;
  logic weDAnalog;
  logic weBDrive;
  logic weDWake;

  assign wrByte = hwdata[PW-1:0];

  // One strobe per stored register, decoded from the captured index
  always_comb begin
    weBLatch = 1'b0;
    weDLatch = 1'b0;
    weBDir = 1'b0;
    weDDir = 1'b0;
    weBPullup = 1'b0;
    weDPullup = 1'b0;
    weDAnalog = 1'b0;
    weBDrive = 1'b0;
    weDWake = 1'b0;
    if (wrPend_r) begin
      case (wrIdx_r)
        IDX_B_OUT_LATCH: weBLatch = 1'b1;
        IDX_D_OUT_LATCH: weDLatch = 1'b1;
        IDX_B_DIR: weBDir = 1'b1;
        IDX_D_DIR: weDDir = 1'b1;
        IDX_B_PULLUP: weBPullup = 1'b1;
        IDX_D_PULLUP: weDPullup = 1'b1;
        IDX_D_ANALOG_SEL: weDAnalog = 1'b1;
        IDX_B_DRIVE_SEL: weBDrive = 1'b1;
        IDX_D_WAKE_EN: weDWake = 1'b1;
        default: begin
          // Readback and unmapped indices have no storage to write
        end
      endcase
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  logic [PW-1:0] portBLatch;
  logic [PW-1:0] portDOutLatch;
  logic [PW-1:0] portBDir;
  logic [PW-1:0] portDDir;
  logic [PW-1:0] portBPullupCtl;
  logic [PW-1:0] portDPullupCtl;
  logic [PW-1:0] portDAnalogSel;
  logic [PW-1:0] portBDriveSel;
  logic [PW-1:0] portDWakeSel;

  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_ALL)) uBLatch (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weBLatch),
    .wrData(wrByte),
    .q_r(portBLatch)
  );

  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_ALL)) uDLatch (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weDLatch),
    .wrData(wrByte),
    .q_r(portDOutLatch)
  );

  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_ALL)) uBDir (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weBDir),
    .wrData(wrByte),
    .q_r(portBDir)
  );

  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_ALL)) uDDir (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weDDir),
    .wrData(wrByte),
    .q_r(portDDir)
  );

  // Bits 4 and 3 are masked out and always hold zero
  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_B_NO43)) uBPullup (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weBPullup),
    .wrData(wrByte),
    .q_r(portBPullupCtl)
  );

  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_ALL)) uDPullup (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weDPullup),
    .wrData(wrByte),
    .q_r(portDPullupCtl)
  );

  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_ALL)) uDAnalog (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weDAnalog),
    .wrData(wrByte),
    .q_r(portDAnalogSel)
  );

  // Bits 4 and 3 have no open-drain option
  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_B_NO43)) uBDrive (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weBDrive),
    .wrData(wrByte),
    .q_r(portBDriveSel)
  );

  gpbr_reg_byte #(.RST_VAL(RST_ZERO), .WMASK(MASK_ALL)) uDWake (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(weDWake),
    .wrData(wrByte),
    .q_r(portDWakeSel)
  );

  // ==========================================================
  // Pin cells
  // ==========================================================
  logic [PW-1:0] portBRead;
  logic [PW-1:0] portDDirEff;

  // An analog channel takes its pin away from the digital output driver
  assign portDDirEff = portDDir & ~portDAnalogSel;

  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : gPins
      // Bits 4 and 3 have no open-drain driver and always read the pin
      localparam bit ALWAYS_RD = B_ALWAYS_READ[gi];
      gpbr_pin_cell #(.OD_CAPABLE(~ALWAYS_RD), .ALWAYS_READ(ALWAYS_RD)) uBCell (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .dirOut(portBDir[gi]),
        .openDrain(portBDriveSel[gi]),
        .latchBit(portBLatch[gi]),
        .pullupEn(portBPullupCtl[gi]),
        .pinIn(portBIn[gi]),
        .pinOut_r(portBOut[gi]),
        .pinOe_r(portBOe[gi]),
        .pullupOn_r(portBPullupOn[gi]),
        .readBit(portBRead[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Port d pin cells
  // ==========================================================
  // Port d has no open-drain mode, so its pull-up follows input mode only
  generate
    for (gi = 0; gi < PW; gi++) begin : gDPins
      gpbr_pin_cell #(.OD_CAPABLE(1'b0), .ALWAYS_READ(1'b0)) uDCell (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .dirOut(portDDirEff[gi]),
        .openDrain(1'b0),
        .latchBit(portDOutLatch[gi]),
        .pullupEn(portDPullupCtl[gi]),
        .pinIn(portDIn[gi]),
        .pinOut_r(portDOut[gi]),
        .pinOe_r(portDOe[gi]),
        .pullupOn_r(portDPullupOn[gi]),
        .readBit()
      );
    end
  endgenerate

  // ==========================================================
  // Secondary function outputs
  // ==========================================================
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      analogInSel <= '0;
    end else begin
      analogInSel <= portDAnalogSel;
    end
  end

  // Wakeup enables are only passed out; the wakeup logic itself sits outside this block
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      keyonWakeEn <= '0;
    end else begin
      keyonWakeEn <= portDWakeSel;
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  // The readback byte samples pins live; writes to it are ignored
  always_comb begin
    rdData_nxt = '0;
    case (addrIdx)
      IDX_B_OUT_LATCH: rdData_nxt[PW-1:0] = portBLatch;
      IDX_D_OUT_LATCH: rdData_nxt[PW-1:0] = portDOutLatch;
      IDX_B_PIN_READ: rdData_nxt[PW-1:0] = portBRead;
      IDX_B_DIR: rdData_nxt[PW-1:0] = portBDir;
      IDX_D_DIR: rdData_nxt[PW-1:0] = portDDir;
      IDX_B_PULLUP: rdData_nxt[PW-1:0] = portBPullupCtl;
      IDX_D_PULLUP: rdData_nxt[PW-1:0] = portDPullupCtl;
      IDX_D_ANALOG_SEL: rdData_nxt[PW-1:0] = portDAnalogSel;
      IDX_B_DRIVE_SEL: rdData_nxt[PW-1:0] = portBDriveSel;
      IDX_D_WAKE_EN: rdData_nxt[PW-1:0] = portDWakeSel;
      default: rdData_nxt = '0;
    endcase
  end

  // Read data is latched at the address phase, so it stands through the data phase
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_r <= '0;
    end else if (addrValid && !hwrite) begin
      hrdata_r <= rdData_nxt;
    end
  end

  // ==========================================================
  // Bus outputs
  // ==========================================================
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;

endmodule

/* File: test/gpbr_gpio_asserts.sv */
`timescale 1ns/1ps
module gpbr_gpio_asserts #(
  parameter int PW = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bus
  input wire logic hsel,
  input wire logic [gpbr_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [gpbr_pkg::DATA_W-1:0] hrdata,
  // Pins
  input wire logic [PW-1:0] portBIn,
  input wire logic [PW-1:0] portBOut,
  input wire logic [PW-1:0] portBOe,
  input wire logic [PW-1:0] portBPullupOn,
  input wire logic [PW-1:0] portDOut,
  input wire logic [PW-1:0] portDOe,
  input wire logic [PW-1:0] portDPullupOn
);
  import gpbr_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  logic dWr;
  logic [IDX_W-1:0] idx;
  assign tk = hsel && hready && htrans[1];
  assign idx = haddr[ADDR_W-1:2];
  assign dWr = tk && hwrite && idx == IDX_D_OUT_LATCH;
  // ==========================================================
  // Assertions
  // ==========================================================
  a_pin_bits43: assert property (tk && !hwrite && idx == IDX_B_PIN_READ
    |=> hrdata[4:3] == $past(portBIn[4:3])) else $error("Pin bits 4 and 3 not read live");
  a_pullup_ro43: assert property (tk && !hwrite && idx == IDX_B_PULLUP
    |=> hrdata[4:3] == 2'h0) else $error("Pull-up bits 4 and 3 not zero");
  a_read_width: assert property (tk && !hwrite
    |=> hrdata[31:8] == 24'h0) else $error("Read data above bit 7 not zero");
  a_rdata_hold: assert property (!(tk && !hwrite)
    |=> $stable(hrdata)) else $error("Read data moved without a read");
  a_dout_cause: assert property ($changed(portDOut)
    |-> $past(dWr, 3)) else $error("Port d drive moved without a latch write");
  a_b_pullup_ok: assert property (
    ((portBPullupOn & portBOe & portBOut) | (portBPullupOn & 8'h18)) == 8'h00) else $error("Port b pull-up on");
  a_d_pullup_in: assert property (
    (portDPullupOn & portDOe) == 8'h00) else $error("Port d pull-up on an output");
  a_reset_outs: assert property ($rose(rst_b)
    |-> (portBOe | portDOe | portBPullupOn | portDPullupOn) == 8'h00) else $error("Pins active after reset");
  c_pin_read: cover property (tk && !hwrite && idx == IDX_B_PIN_READ);
  c_od_pullup: cover property (|(portBPullupOn & portBOe));
  c_d_output: cover property ($rose(|portDOe));
endmodule

bind gpbr_gpio_top gpbr_gpio_asserts #(.PW(PW)) gpbr_gpio_asserts_inst (
  .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .portBIn(portBIn), .portBOut(portBOut),
  .portBOe(portBOe), .portBPullupOn(portBPullupOn), .portDOut(portDOut), .portDOe(portDOe),
  .portDPullupOn(portDPullupOn));

/* File: test/gpbr_board_model.sv */
`timescale 1ns/1ps
module gpbr_board_model #(
  parameter int PW = 8
) (
  // Clock
  input wire logic core_clk,
  // Device drive
  input wire logic [PW-1:0] bOut,
  input wire logic [PW-1:0] bOe,
  input wire logic [PW-1:0] bPu,
  input wire logic [PW-1:0] dOut,
  input wire logic [PW-1:0] dOe,
  input wire logic [PW-1:0] dPu,
  // Board drivers
  input wire logic [PW-1:0] extEn,
  input wire logic [PW-1:0] extVal,
  // Resolved pins
  output logic [PW-1:0] bPin,
  output logic [PW-1:0] dPin
);
  logic [PW-1:0] flt_r;
  // Lines nobody drives or pulls toggle, so a stale level can never pass as a read
  always_ff @(posedge core_clk) begin
    flt_r <= (flt_r === '1) ? '0 : '1;
  end
  // Device driver wins over the board; a connected pull-up lifts an idle line
  assign bPin = (bOe & bOut) | (~bOe & extEn & extVal) | (~bOe & ~extEn & (bPu | flt_r));
  assign dPin = (dOe & dOut) | (~dOe & extEn & extVal) | (~dOe & ~extEn & (dPu | flt_r));
endmodule

/* File: test/test_gpbr_gpio_top.sv */
`timescale 1ns/1ps
module test_gpbr_gpio_top;
  import gpbr_pkg::*;
  logic core_clk = 0;
  logic rst_b = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [ADDR_W-1:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [DATA_W-1:0] hwdata = '0;
  logic [DATA_W-1:0] rd;
  logic [7:0] extEn = 8'h00;
  logic [7:0] extVal = 8'h00;
  logic [7:0] cfg [9];
  logic [7:0] odE;
  logic [7:0] dEff;
  logic [IDX_W-1:0] wIdx [9] = '{IDX_B_DIR, IDX_B_DRIVE_SEL, IDX_B_OUT_LATCH, IDX_B_PULLUP, IDX_D_DIR,
    IDX_D_OUT_LATCH, IDX_D_PULLUP, IDX_D_ANALOG_SEL, IDX_D_WAKE_EN};
  wire [DATA_W-1:0] hrdata;
  wire hreadyout, hresp;
  wire [7:0] portBIn, portBOut, portBOe, portBPullupOn, portDIn, portDOut, portDOe, portDPullupOn;
  wire [7:0] analogInSel, keyonWakeEn;
  int n_errors = 0;
  int checked = 0;

  initial forever #10 core_clk = ~core_clk;

  gpbr_gpio_top gpbr_gpio_top_inst (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
    .portBPullupOn(portBPullupOn), .portDIn(portDIn), .portDOut(portDOut), .portDOe(portDOe),
    .portDPullupOn(portDPullupOn), .analogInSel(analogInSel), .keyonWakeEn(keyonWakeEn));
  gpbr_board_model gpbr_board_model_inst (.core_clk(core_clk), .bOut(portBOut), .bOe(portBOe),
    .bPu(portBPullupOn), .dOut(portDOut), .dOe(portDOe), .dPu(portDPullupOn), .extEn(extEn),
    .extVal(extVal), .bPin(portBIn), .dPin(portDIn));

  // ==========================================================
  // Tasks and expectations
  // ==========================================================
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Waits for hready at a rising edge; a bus that never answers ends the run
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      $display("Error at %0t: bus timeout", $time);
      end_of_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {idx, 2'b00};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd[7:0], exp);
    check({6'h0, hreadyout, hresp}, 8'h02);
  endtask

  // Pin level seen by the board, with drive select already masked
  function automatic logic [7:0] pin_exp(input logic [7:0] dir, od, lat, en, val);
    logic [7:0] oe;
    oe = dir & ~(od & lat);
    return (oe & lat & ~od) | (~oe & ((en & val) | ~en));
  endfunction

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    void'($urandom(80546));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 9; k++) rd_chk(wIdx[k], 8'h00);
    bus(1'b1, 14'h0100, 8'hff);
    rd_chk(14'h0100, 8'h00);
    $display("Test reset values done");
    for (int it = 0; it < 24; it++) begin
      for (int k = 0; k < 9; k++) begin
        cfg[k] = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($urandom);
        bus(1'b1, wIdx[k], cfg[k]);
      end
      odE = cfg[1] & MASK_B_NO43;
      dEff = cfg[4] & ~cfg[7];
      extEn <= ~(cfg[3] & MASK_B_NO43) | 8'($urandom);
      extVal <= 8'($urandom);
      repeat (3) @(posedge core_clk);
      check(portBOe, cfg[0] & ~(odE & cfg[2]));
      check(portBOut, cfg[2] & ~odE);
      check(portBPullupOn, cfg[3] & MASK_B_NO43 & (~cfg[0] | odE));
      check(portDOe, dEff);
      check(portDOut, cfg[5]);
      check(portDPullupOn, cfg[6] & ~dEff);
      check(analogInSel, cfg[7]);
      check(keyonWakeEn, cfg[8]);
      bus(1'b1, IDX_B_PIN_READ, 8'($urandom));
      rd_chk(IDX_B_PIN_READ, (~cfg[0] | odE | B_ALWAYS_READ) & pin_exp(cfg[0], odE, cfg[2], extEn, extVal));
      rd_chk(IDX_B_PULLUP, cfg[3] & MASK_B_NO43);
      rd_chk(IDX_B_DRIVE_SEL, odE);
      rd_chk(IDX_D_OUT_LATCH, cfg[5]);
    end
    $display("Test pin configurations done");
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk(IDX_D_OUT_LATCH, 8'h00);
    rd_chk(IDX_B_PULLUP, 8'h00);
    check(portDOe | portBOe, 8'h00);
    $display("Test reset in mid-run done");
    end_of_test();
  end
endmodule
